// ==== hw/lem_top.sv ====
// laser emission mode control: source selection and emission gating
//
// What this block does, and what it expects of the far side (R17, R20)
// R1 - external control: emission follows modulation pin difference
// R2 - internal control: emission on/off commands switch emission
// R3 - local mode: guide beam only by commands
// R4 - guide beam changes at least 10ms after request
// R5 - ready refused while guide beam is on
// R6 - local mode: nonzero program number means programming
// R7 - internal programming: emission-on command starts waveform
// R8 - internal programming: emission-off command aborts immediately
// R9 - external programming: modulation rise starts, fall aborts
// R10 - remote: analog port sets power when selected and the program pins are zero
// R11 - remote: analog select low uses percentage command
// R12 - remote: source select high means command emission
// R13 - remote: source select low uses modulation and gate
// R14 - remote: source select high, guide beam by commands
// R15 - remote: source select low, guide follows input
// R16 - remote: nonzero program pins, gate-driven programming
// R17 - far side holds modulation longer than program
// R18 - early trigger fall (modulation, or the gate pin in remote) flags abnormal termination
// R19 - analog and external selections survive power cycles
// R20 - far side waits for ready before gating emission
// R21 - local mode: enable/disable commands set external control
// R22 - discrete inputs pass two synchroniser flops
`timescale 1ns/1ps
`include "lem_defines.svh"
module lem_top #(
	parameter int unsigned GB_DELAY_CYC = `LEM_GB_DELAY_CYC,
	parameter int unsigned PROG_W       = 7
) (
	input  wire logic               mclk,
	input  wire logic               resetn,
	input  wire logic               hsel,
	input  wire logic [7:0]         haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic                    hreadyout,
	output logic                    hresp,
	output logic [31:0]             hrdata,
	input  wire lem_pkg::lem_pins_s pins,
	input  wire logic [7:0]         analog_level,
	input  wire logic               waveform_done,
	input  wire logic               retained_ext_mode,
	input  wire logic               retained_analog_mode,
	output logic                    persist_ext_mode,
	output logic                    persist_analog_mode,
	output logic                    emission,
	output logic                    guide_beam,
	output logic                    ready_permit,
	output logic [7:0]              power_setpoint,
	output logic                    power_from_analog,
	output logic                    waveform_run,
	output logic [6:0]              program_number,
	output logic                    abnormal_stop
);
	import lem_pkg::*;

	lem_pins_s  sync1_q;
	lem_pins_s  sync2_q;
	lem_cmd_s   cmd;
	logic       dph_q;
	logic       dwr_q;
	logic [5:0] dadr_q;
	logic [31:0] cfg_q;
	logic [31:0] rdata_q;
	logic       ext_mode_q;
	logic       analog_mode_q;
	logic       restore_q;
	logic       em_cmd_q;
	logic       gb_cmd_q;
	logic       gb_q;
	logic [19:0] gb_cnt_q;
	logic       trig_q;
	logic       abn_q;
	logic       clr_abn;
	lem_prog_e  prog_q;
	logic       remote;
	logic       rem_en;
	logic       pins_zero;
	logic       prog_mode;
	logic       ext_ctrl;
	logic       analog_sel;
	logic       mod_level;
	logic       trig;
	logic       trig_rise;
	logic       trig_fall;
	logic       start;
	logic       abort;
	logic       gb_target;
	logic       cmd_path;

	// two flops on every discrete input before anything decodes them
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= pins; // [R22]
			sync2_q <= sync1_q; // [R22]
		end
	end

	// ahb-lite address phase capture; zero wait states, always okay
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			dph_q  <= 1'b0;
			dwr_q  <= 1'b0;
			dadr_q <= '0;
		end else if (hready) begin
			dph_q  <= hsel && htrans[1];
			dwr_q  <= hsel && htrans[1] && hwrite;
			dadr_q <= haddr[7:2];
		end
	end
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// command writes become one-cycle pulses in the data phase
	always_comb begin
		cmd = '0;
		if (dph_q && dwr_q && dadr_q == `LEM_ADDR_CMD) begin
			cmd = hwdata[7:0];
		end
	end
	assign clr_abn = dph_q && dwr_q && dadr_q == `LEM_ADDR_CLR && hwdata[0];

	// configuration: power percentage and local program number
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cfg_q <= `LEM_CFG_RESET;
		end else if (dph_q && dwr_q && dadr_q == `LEM_ADDR_CFG) begin
			cfg_q <= hwdata & 32'h0000_7F7F;
		end
	end

	// read data is prepared in the address phase so it comes from a flop
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rdata_q <= '0;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			case (haddr[7:2])
				// forward a configuration write still in its data phase
				`LEM_ADDR_CFG:    rdata_q <= (dph_q && dwr_q && dadr_q == `LEM_ADDR_CFG)
					? (hwdata & 32'h0000_7F7F) : cfg_q;
				`LEM_ADDR_STATUS: rdata_q <= {22'h0, abn_q, waveform_run,
					prog_mode, power_from_analog, ext_ctrl, remote,
					ready_permit, gb_target, guide_beam, emission};
				default:          rdata_q <= 32'h0000_0000;
			endcase
		end
	end
	assign hrdata = rdata_q;

	// mode decode: local mode uses software state, remote uses pins
	assign remote     = sync2_q.remote_mode;
	assign rem_en     = sync2_q.remote_enable_input;
	assign pins_zero  = sync2_q.program_number_inputs == '0;
	assign prog_mode  = remote ? (rem_en && !pins_zero) // [R16]
		: (cfg_q[`LEM_CFG_PROG_LSB +: PROG_W] != '0); // [R6]
	assign ext_ctrl   = remote ? (rem_en && !sync2_q.emission_source_select) // [R12] [R13]
		: ext_mode_q; // [R21]
	assign analog_sel = remote ? (rem_en && sync2_q.analog_power_select && pins_zero) // [R10]
		: analog_mode_q;
	assign cmd_path   = !remote || !rem_en || sync2_q.emission_source_select;

	// differential modulation: on when positive is high and negative low
	assign mod_level = sync2_q.modulation_positive && !sync2_q.modulation_negative; // [R1]

	// restore saved selections once, the cycle after reset releases
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			restore_q     <= 1'b1;
			ext_mode_q    <= 1'b0;
			analog_mode_q <= 1'b0;
		end else begin
			restore_q <= 1'b0;
			if (restore_q) begin
				ext_mode_q    <= retained_ext_mode; // [R19]
				analog_mode_q <= retained_analog_mode; // [R19]
			end else begin
				if (cmd.ext_en && !remote) ext_mode_q <= 1'b1; // [R21]
				else if (cmd.ext_dis && !remote) ext_mode_q <= 1'b0; // [R21]
				if (cmd.an_en && !remote) analog_mode_q <= 1'b1;
				else if (cmd.an_dis && !remote) analog_mode_q <= 1'b0;
			end
		end
	end
	// the storage outside keeps these across power loss
	assign persist_ext_mode    = ext_mode_q; // [R19]
	assign persist_analog_mode = analog_mode_q; // [R19]

	// internal emission latch; off wins if both arrive together
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			em_cmd_q <= 1'b0;
		end else if (cmd.em_off || ext_ctrl) begin
			em_cmd_q <= 1'b0; // [R2]
		end else if (cmd.em_on) begin
			em_cmd_q <= 1'b1; // [R2]
		end
	end

	// guide beam request from commands, or from the pin in remote external
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			gb_cmd_q <= 1'b0;
		end else if (cmd.gb_off) begin
			gb_cmd_q <= 1'b0; // [R3] [R14]
		end else if (cmd.gb_on) begin
			gb_cmd_q <= 1'b1; // [R3] [R14]
		end
	end
	assign gb_target = (remote && rem_en && !sync2_q.emission_source_select)
		? sync2_q.guide_beam_input : gb_cmd_q; // [R15] [R3]

	// the beam module is slow to answer, so a change waits out the delay
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			gb_q     <= 1'b0;
			gb_cnt_q <= '0;
		end else if (gb_target == gb_q) begin
			gb_cnt_q <= '0;
		end else if (gb_cnt_q == 20'(GB_DELAY_CYC - 1)) begin
			gb_q     <= gb_target; // [R4]
			gb_cnt_q <= '0;
		end else begin
			gb_cnt_q <= gb_cnt_q + 20'h00001; // [R4]
		end
	end
	assign guide_beam = gb_q;

	// ready only while main power is requested and the beam is dark
	assign ready_permit = sync2_q.main_power_request && !gb_q; // [R5]

	// program trigger: gate pin in remote, modulation if external
	assign trig      = remote ? sync2_q.remote_emission_gate : mod_level; // [R16] [R9]
	assign trig_rise = trig && !trig_q;
	assign trig_fall = !trig && trig_q;
	assign start = prog_mode && (ext_ctrl || remote ? trig_rise : cmd.em_on); // [R7] [R9]
	assign abort = (ext_ctrl || remote) ? trig_fall : cmd.em_off; // [R8] [R9]

	// waveform run state
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			trig_q <= 1'b0;
			prog_q <= LEM_IDLE;
		end else begin
			trig_q <= trig;
			case (prog_q)
				LEM_IDLE: if (start) prog_q <= LEM_RUN; // [R7] [R9]
				LEM_RUN:  if (abort || waveform_done || !prog_mode) prog_q <= LEM_IDLE; // [R8]
				default:  prog_q <= LEM_IDLE;
			endcase
		end
	end
	assign waveform_run = prog_q == LEM_RUN;

	// early fall of the trigger while running is reported; set beats clear
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			abn_q <= 1'b0;
		end else if (waveform_run && trig_fall && !waveform_done && (ext_ctrl || remote)) begin
			abn_q <= 1'b1; // [R18]
		end else if (clr_abn) begin
			abn_q <= 1'b0;
		end
	end
	assign abnormal_stop = abn_q;

	// emission selection; remote external also needs the gate pin
	always_comb begin
		if (prog_mode) begin
			emission = waveform_run; // [R16]
		end else if (ext_ctrl) begin
			emission = remote ? (mod_level && sync2_q.remote_emission_gate) // [R13]
				: mod_level; // [R1]
		end else begin
			emission = cmd_path && em_cmd_q; // [R2] [R12]
		end
	end

	// power setpoint from analog port or percentage field
	assign power_from_analog = analog_sel; // [R10]
	assign power_setpoint = analog_sel ? analog_level
		: {1'b0, cfg_q[`LEM_CFG_PWR_LSB +: 7]}; // [R11]
	assign program_number = remote ? sync2_q.program_number_inputs
		: cfg_q[`LEM_CFG_PROG_LSB +: PROG_W];

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence gb_req_s;
		gb_target != gb_q;
	endsequence
	sequence run_s;
		waveform_run;
	endsequence

	AST_GB_HOLDS: assert property (gb_req_s ##0 $changed(gb_target) |=> $stable(gb_q)) // [R4]
		else $error("guide beam changed before delay");
	AST_GB_CNT: assert property (gb_cnt_q <= 20'(GB_DELAY_CYC - 1)) // [R4]
		else $error("guide beam counter overran");
	AST_READY: assert property (gb_q |-> !ready_permit) // [R5]
		else $error("ready permitted with beam on");
	AST_EXT_MOD: assert property (!prog_mode && ext_ctrl && !remote |-> emission == mod_level) // [R1]
		else $error("external emission not following modulation");
	AST_EM_OFF: assert property (!prog_mode && !ext_ctrl && cmd.em_off |=> !em_cmd_q) // [R2]
		else $error("emission-off command ignored");
	AST_EM_ON: assert property (!ext_ctrl && cmd.em_on && !cmd.em_off |=> em_cmd_q) // [R2]
		else $error("emission-on command ignored");
	AST_ABORT: assert property (run_s ##0 abort |=> !waveform_run) // [R8] [R9]
		else $error("waveform not aborted");
	AST_START: assert property (!waveform_run && start |=> run_s) // [R7] [R9]
		else $error("waveform did not start");
	AST_ABN: assert property (run_s ##0 (trig_fall && !waveform_done && (ext_ctrl || remote))
		|=> abn_q) // [R18]
		else $error("abnormal stop not flagged");
	AST_ANALOG: assert property (remote && !sync2_q.analog_power_select |-> !power_from_analog) // [R11]
		else $error("analog source used with select low");
	AST_LOCAL_GB: assert property (!remote |-> gb_target == gb_cmd_q) // [R3]
		else $error("local guide beam followed the pin");
	AST_SYNC: assert property (sync2_q == $past(pins, 2) || $past(!resetn, 2)) // [R22]
		else $error("input not two flops late");
endmodule : lem_top

// ==== hw/lem_defines.svh ====
// constants for the laser emission mode control block
`ifndef LEM_DEFINES_SVH
`define LEM_DEFINES_SVH
`define LEM_ADDR_CMD      6'h00
`define LEM_ADDR_CFG      6'h01
`define LEM_ADDR_STATUS   6'h02
`define LEM_ADDR_CLR      6'h03
`define LEM_CMD_EM_ON     0
`define LEM_CMD_EM_OFF    1
`define LEM_CMD_GB_ON     2
`define LEM_CMD_GB_OFF    3
`define LEM_CMD_EXT_EN    4
`define LEM_CMD_EXT_DIS   5
`define LEM_CMD_AN_EN     6
`define LEM_CMD_AN_DIS    7
`define LEM_CFG_PWR_LSB   0
`define LEM_CFG_PROG_LSB  8
`define LEM_CFG_RESET     32'h0000_0000
`define LEM_GB_DELAY_MS   10
`define LEM_CLK_MHZ       100
`define LEM_GB_DELAY_CYC  (`LEM_GB_DELAY_MS * 1000 * `LEM_CLK_MHZ)
`endif

// ==== hw/lem_pkg.sv ====
// types shared by the laser emission mode control block
package lem_pkg;
	// discrete inputs from the machine control board and key switch
	typedef struct packed {
		logic       remote_mode;
		logic       remote_enable_input;
		logic       remote_emission_gate;
		logic       emission_source_select;
		logic       guide_beam_input;
		logic       analog_power_select;
		logic [6:0] program_number_inputs;
		logic       main_power_request;
		logic       modulation_positive;
		logic       modulation_negative;
	} lem_pins_s;
	// one-cycle command pulses decoded from the command register
	typedef struct packed {
		logic an_dis;
		logic an_en;
		logic ext_dis;
		logic ext_en;
		logic gb_off;
		logic gb_on;
		logic em_off;
		logic em_on;
	} lem_cmd_s;
	typedef enum logic [1:0] {LEM_IDLE, LEM_RUN} lem_prog_e;
endpackage : lem_pkg

// ==== tb/lem_board_model.sv ====
// far side model: control board pins and the waveform engine
`timescale 1ns/1ps
module lem_board_model #(
	parameter int PROG_LEN = 40
) (
	mclk,
	req,
	early_fall,
	ready_permit,
	waveform_run,
	pins,
	waveform_done
);
	import lem_pkg::*;
	input  wire logic      mclk;
	input  wire lem_pins_s req;
	input  wire logic      early_fall;
	input  wire logic      ready_permit;
	input  wire logic      waveform_run;
	output lem_pins_s      pins;
	output logic           waveform_done;
	int run_cnt = 0;
	// pins change just after an edge; the gate waits for ready
	always_ff @(posedge mclk) begin
		pins <= req;
		pins.remote_emission_gate <= req.remote_emission_gate
			& (ready_permit | pins.remote_emission_gate);
		// modulation outlasts the program unless a fall is forced
		pins.modulation_positive <= req.modulation_positive | (pins.modulation_positive
			& waveform_run & ~waveform_done & ~early_fall);
	end
	// program ends a fixed time after it starts
	always_ff @(posedge mclk) begin
		run_cnt <= waveform_run ? run_cnt + 1 : 0;
		waveform_done <= waveform_run && run_cnt == PROG_LEN - 1;
	end
endmodule : lem_board_model

// ==== tb/tb.sv ====
// self-checking bench for the emission mode control block
`timescale 1ns/1ps
`include "lem_defines.svh"
module tb;
	import lem_pkg::*;
	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic        hsel = 1'b0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, hrdata, rv;
	logic        hreadyout, hresp, ef = 1'b0, rext = 1'b0, rana = 1'b0;
	logic        pext, pana, em, gb, rdy, pfa, run, done, ab;
	logic [7:0]  alvl = 8'hA5, psp;
	logic [6:0]  pnum;
	lem_pins_s   req = '0, pins;
	int          err_count = 0, n_compared = 0;
	// 100 MHz clock
	always #5 mclk = ~mclk;
	lem_top #(.GB_DELAY_CYC(8)) uut (.mclk(mclk), .resetn(resetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.pins(pins), .analog_level(alvl), .waveform_done(done), .retained_ext_mode(rext),
		.retained_analog_mode(rana), .persist_ext_mode(pext), .persist_analog_mode(pana),
		.emission(em), .guide_beam(gb), .ready_permit(rdy), .power_setpoint(psp),
		.power_from_analog(pfa), .waveform_run(run), .program_number(pnum),
		.abnormal_stop(ab));
	lem_board_model brd (.mclk(mclk), .req(req), .early_fall(ef), .ready_permit(rdy),
		.waveform_run(run), .pins(pins), .waveform_done(done));
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc
	// wait for hready with a bound; a hang ends the run
	task automatic wrdy();
		int k;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (hreadyout !== 1'b1) begin
			err_count++;
			end_of_test();
		end
	endtask : wrdy
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wrdy();
		htrans <= 2'h0;
		hwdata <= d;
		wrdy();
		rv = hrdata;
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		chk("hrdata", e, rv);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : rd
	// command pulse, then let synchronisers and state settle
	task automatic cmd(input int b);
		xfer(8'h00, 1'b1, 32'h1 << b);
		cyc(4);
	endtask : cmd
	initial begin
		cyc(10);
		resetn <= 1'b1;
		cyc(2);
		chk("persist", 2'h0, {pext, pana});
		rd(8'h04, 32'h0);
		xfer(8'h04, 1'b1, 32'h0000_002A);
		rd(8'h04, 32'h0000_002A);
		xfer(8'h10, 1'b1, 32'hFFFF_FFFF);
		rd(8'h10, 32'h0);
		rd(8'h00, 32'h0);
		// local analog selection is a saved mode as well
		cmd(`LEM_CMD_AN_EN);
		chk("pwr pana", {2'h3, 8'hA5}, {pfa, pana, psp});
		cmd(`LEM_CMD_AN_DIS);
		chk("pwr pana", {2'h0, 8'h2A}, {pfa, pana, psp});
		cmd(`LEM_CMD_EM_ON);
		chk("em", 1, em);
		cmd(`LEM_CMD_EM_OFF);
		chk("em", 0, em);
		cmd(`LEM_CMD_EXT_EN);
		req.modulation_positive <= 1'b1;
		cyc(4);
		chk("em", 1, em);
		req.modulation_negative <= 1'b1;
		cyc(4);
		chk("em", 0, em);
		cmd(`LEM_CMD_EXT_DIS);
		req.modulation_negative <= 1'b0;
		cyc(4);
		chk("em", 0, em);
		req.modulation_positive <= 1'b0;
		req.guide_beam_input <= 1'b1;
		req.main_power_request <= 1'b1;
		cyc(14);
		chk("gb", 0, gb);
		chk("rdy", 1, rdy);
		cmd(`LEM_CMD_GB_ON);
		chk("gb", 0, gb);
		cyc(10);
		chk("gb", 1, gb);
		chk("rdy", 0, rdy);
		cmd(`LEM_CMD_GB_OFF);
		cyc(10);
		chk("rdy", 1, rdy);
		req.guide_beam_input <= 1'b0;
		xfer(8'h04, 1'b1, 32'h0000_032A);
		cyc(4);
		rd(8'h08, 32'h0000_0088);
		chk("pnum", 7'h03, pnum);
		cmd(`LEM_CMD_EM_ON);
		chk("run", 1, run);
		cmd(`LEM_CMD_EM_OFF);
		chk("run em", 0, {run, em});
		cmd(`LEM_CMD_EXT_EN);
		req.modulation_positive <= 1'b1;
		cyc(5);
		chk("run", 1, run);
		req.modulation_positive <= 1'b0;
		cyc(60);
		chk("run ab", 0, {run, ab});
		req.modulation_positive <= 1'b1;
		cyc(4);
		ef <= 1'b1;
		req.modulation_positive <= 1'b0;
		cyc(5);
		chk("run ab", 2'h1, {run, ab});
		xfer(8'h0C, 1'b1, 32'h1);
		cyc(2);
		chk("ab", 0, ab);
		ef <= 1'b0;
		cmd(`LEM_CMD_EXT_DIS);
		xfer(8'h04, 1'b1, 32'h0000_002A);
		req.remote_mode <= 1'b1;
		req.remote_enable_input <= 1'b1;
		req.analog_power_select <= 1'b1;
		req.emission_source_select <= 1'b1;
		cyc(4);
		chk("pwr", {1'b1, 8'hA5}, {pfa, psp});
		req.analog_power_select <= 1'b0;
		cmd(`LEM_CMD_EM_ON);
		chk("pwr", {1'b0, 8'h2A}, {pfa, psp});
		chk("em", 1, em);
		cmd(`LEM_CMD_GB_ON);
		cyc(10);
		chk("gb", 1, gb);
		cmd(`LEM_CMD_GB_OFF);
		cmd(`LEM_CMD_EM_OFF);
		cyc(10);
		req.emission_source_select <= 1'b0;
		req.remote_emission_gate <= 1'b1;
		req.modulation_positive <= 1'b1;
		cyc(5);
		chk("em", 1, em);
		req.remote_emission_gate <= 1'b0;
		cyc(4);
		chk("em", 0, em);
		req.modulation_positive <= 1'b0;
		req.guide_beam_input <= 1'b1;
		cyc(14);
		chk("gb rdy", 2'h2, {gb, rdy});
		req.guide_beam_input <= 1'b0;
		req.program_number_inputs <= 7'h05;
		cyc(14);
		chk("gb pnum", {1'b0, 7'h05}, {gb, pnum});
		req.remote_emission_gate <= 1'b1;
		cyc(5);
		chk("run", 1, run);
		req.remote_emission_gate <= 1'b0;
		cyc(5);
		chk("run ab", 2'h1, {run, ab});
		req <= '0;
		rext <= 1'b1;
		rana <= 1'b1;
		resetn <= 1'b0;
		cyc(10);
		resetn <= 1'b1;
		cyc(2);
		chk("persist", 2'h3, {pext, pana});
		end_of_test();
	end
endmodule : tb
